// ==== pllcfg_pkg.sv ====
/*
 * Shared constants and types for the loop one configuration bank.
 * Assumes an AXI4-Lite master with 32-bit data and one clock domain.
 */
package pllcfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 7;
  localparam logic [6:0] IDX_CONTROL_ONE = 7'h39;
  localparam logic [6:0] IDX_INT_DIV_HIGH = 7'h3a;
  localparam logic [6:0] IDX_INT_DIV_LOW = 7'h3b;
  localparam logic [6:0] IDX_NUM_TOP = 7'h3c;
  localparam logic [6:0] IDX_NUM_MID = 7'h3d;
  localparam logic [6:0] IDX_NUM_LOW = 7'h3e;
  localparam logic [6:0] IDX_DEN_TOP = 7'h3f;
  localparam logic [6:0] IDX_DEN_MID = 7'h40;
  localparam logic [6:0] IDX_DEN_LOW = 7'h41;
  localparam logic [6:0] IDX_MOD_CONTROL = 7'h42;
  localparam logic [6:0] IDX_STATUS = 7'h43;
  localparam int unsigned CFG_NUM = 10;
  localparam int unsigned REG_W = 8;

  // ----------------------------------------------------------------
  // Reset values and writable masks, entry 0 is the control register
  // ----------------------------------------------------------------
  localparam logic [CFG_NUM-1:0][7:0] RST_TABLE = {
    8'h0c, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h66, 8'h00, 8'h18};
  localparam logic [CFG_NUM-1:0][7:0] MASK_TABLE = {
    8'h0f, 8'hff, 8'hff, 8'h3f, 8'hff,
    8'hff, 8'h3f, 8'hff, 8'h0f, 8'h3f};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned DOUBLER_BIT = 4;
  localparam int unsigned PUMP_LSB = 0;
  localparam int unsigned DITHER_LSB = 2;
  localparam int unsigned ORDER_LSB = 0;
  localparam int unsigned TOP_W = 6;
  localparam int unsigned HIGH_W = 4;
  localparam int unsigned STAT_FRAC_BIT = 0;
  localparam int unsigned STAT_DITHER_BIT = 1;
  localparam int unsigned STAT_FAULT_BIT = 2;

  // ----------------------------------------------------------------
  // Field codes and decoded values (pump current in 0.1 mA units)
  // ----------------------------------------------------------------
  localparam logic [3:0] PUMP_STEP_MAX = 4'h7;
  localparam logic [3:0] PUMP_HIGH_CODE = 4'h8;
  localparam logic [7:0] PUMP_HIGH_UNITS = 8'h40;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam logic [1:0] ORDER_INTEGER = 2'h0;
  localparam logic [11:0] RATIO_MIN = 12'h001;
  localparam logic [11:0] RST_RATIO = 12'h066;

  // ----------------------------------------------------------------
  // Bus answers and state types
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } pllcfg_wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } pllcfg_rd_state_t;

endpackage

// ==== pllcfg_wr_capture.sv ====
/*
 * Write address and write data holding stage for the AXI4-Lite slave.
 * Assumes the parent pulses i_take once it has used both halves.
 */
`timescale 1ns/10ps
`default_nettype none
module pllcfg_wr_capture #(
  parameter int unsigned P_ADDR_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Write address channel
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [P_ADDR_W-1:0] i_awaddr,
  // Write data channel
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // Held request
  input wire logic i_take,
  output logic o_pending,
  output logic [P_ADDR_W-1:0] o_addr,
  output logic [31:0] o_data,
  output logic [3:0] o_strb
);

  logic aw_full;
  logic w_full;

  // Each half is taken independently, in either order
  assign o_awready = !aw_full;
  assign o_wready = !w_full;
  assign o_pending = aw_full && w_full;

  // Address holding register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full <= 1'b0;
      o_addr <= '0;
    end else if (i_awvalid && !aw_full) begin
      aw_full <= 1'b1;
      o_addr <= i_awaddr;
    end else if (i_take) begin
      aw_full <= 1'b0;
    end
  end

  // Data holding register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_full <= 1'b0;
      o_data <= '0;
      o_strb <= '0;
    end else if (i_wvalid && !w_full) begin
      w_full <= 1'b1;
      o_data <= i_wdata;
      o_strb <= i_wstrb;
    end else if (i_take) begin
      w_full <= 1'b0;
    end
  end

endmodule // pllcfg_wr_capture
`default_nettype wire

// ==== pllcfg_field_decode.sv ====
/*
 * Registered decode of loop one fields into values for the analog loop.
 * Assumes raw field values from the register bank on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pllcfg_field_decode (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Raw fields
  input wire logic [3:0] i_pump_gain,
  input wire logic [11:0] i_int_divider,
  input wire logic [1:0] i_dither_select,
  input wire logic [1:0] i_modulator_order,
  // Decoded values
  output logic [7:0] o_pump_current,
  output logic [11:0] o_div_ratio,
  output logic o_frac_active,
  output logic o_dither_active
);

  logic [7:0] next_pump_current;

  // Codes 1 to 7 step by 0.4 mA, code 8 is the high setting
  always_comb begin
    if (i_pump_gain == pllcfg_pkg::PUMP_HIGH_CODE) begin
      next_pump_current = pllcfg_pkg::PUMP_HIGH_UNITS;
    end else if (i_pump_gain <= pllcfg_pkg::PUMP_STEP_MAX) begin
      next_pump_current = {2'h0, i_pump_gain, 2'h0};
    end else begin
      next_pump_current = 8'h00;
    end
  end

  // Decoded outputs held in flip-flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pump_current <= pllcfg_pkg::PUMP_HIGH_UNITS;
      o_div_ratio <= pllcfg_pkg::RST_RATIO;
      o_frac_active <= 1'b0;
      o_dither_active <= 1'b0;
    end else begin
      o_pump_current <= next_pump_current;
      o_div_ratio <= (i_int_divider == 12'h000) ?
        pllcfg_pkg::RATIO_MIN : i_int_divider;
      o_frac_active <=
        (i_modulator_order != pllcfg_pkg::ORDER_INTEGER);
      o_dither_active <=
        (i_dither_select != pllcfg_pkg::DITHER_OFF);
    end
  end

endmodule // pllcfg_field_decode
`default_nettype wire

// ==== pllcfg_regs.sv ====
/*
 * Loop one divider configuration bank with an AXI4-Lite slave port.
 * Unmapped words answer SLVERR; reserved bits read zero except control bit 5.
 * Assumes one clock and a single-outstanding AXI4-Lite master.
 */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pllcfg_regs #(
  parameter int unsigned P_ADDR_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [P_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [P_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Raw fields toward the loop
  output logic o_ref_doubler_enable,
  output logic [3:0] o_loop1_pump_gain,
  output logic [11:0] o_loop1_int_divider,
  output logic [21:0] o_loop1_frac_numerator,
  output logic [21:0] o_loop1_frac_denominator,
  output logic [1:0] o_loop1_dither_select,
  output logic [1:0] o_loop1_modulator_order,
  // Decoded values toward the loop
  output logic [7:0] o_loop1_pump_current,
  output logic [11:0] o_loop1_div_ratio,
  output logic o_loop1_frac_active,
  output logic o_loop1_dither_active,
  output logic o_loop1_config_fault
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Entry number wide enough for every byte
  localparam int unsigned ENT_W = 4;

  // Bus state machines
  pllcfg_pkg::pllcfg_wr_state_t wr_state;
  pllcfg_pkg::pllcfg_rd_state_t rd_state;

  // Configuration bytes, entry 0 is control
  logic [7:0] cfg [pllcfg_pkg::CFG_NUM];

  // Held write request and its decode
  logic wr_pending;
  logic wr_take;
  logic wr_apply;
  logic [P_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [6:0] wr_index;
  logic wr_in_page;
  logic wr_mapped;
  logic [ENT_W-1:0] wr_entry;

  // Read decode and data select
  logic [6:0] rd_index;
  logic rd_in_page;
  logic rd_mapped;
  logic rd_is_status;
  logic [ENT_W-1:0] rd_entry;
  logic [7:0] status;
  logic [7:0] next_rd_byte;
  logic [1:0] next_rd_resp;

  // Decoded loop values and fault input
  logic [7:0] pump_current;
  logic [11:0] div_ratio;
  logic frac_active;
  logic dither_active;
  logic den_zero;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------

  // Holding stage for address and data halves
  pllcfg_wr_capture #(
    .P_ADDR_W(P_ADDR_W)
  ) u_wr_capture (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_take(wr_take),
    .o_pending(wr_pending),
    .o_addr(wr_addr),
    .o_data(wr_data),
    .o_strb(wr_strb)
  );

  // One write at a time: take only when no response is owed
  assign wr_take = wr_pending && (wr_state == pllcfg_pkg::WR_IDLE);

  // Word index decode of the held write address
  assign wr_index = wr_addr[8:2];
  assign wr_in_page = ((wr_addr >> 9) == '0);

  // Status word counts as mapped; writes to it are dropped
  assign wr_mapped = wr_in_page &&
    (wr_index >= pllcfg_pkg::IDX_CONTROL_ONE) &&
    (wr_index <= pllcfg_pkg::IDX_STATUS);
  assign wr_entry = ENT_W'(wr_index - pllcfg_pkg::IDX_CONTROL_ONE);

  // A write lands only with byte lane 0 on a mapped word
  assign wr_apply = wr_take && wr_mapped && wr_strb[0];

  // Response channel: answer one cycle after the write is applied
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_state <= pllcfg_pkg::WR_IDLE;
      o_bvalid <= 1'b0;
      o_bresp <= pllcfg_pkg::RESP_OKAY;
    end else begin
      case (wr_state)
        pllcfg_pkg::WR_IDLE: begin
          if (wr_take) begin
            wr_state <= pllcfg_pkg::WR_RESP;
            o_bvalid <= 1'b1;
            o_bresp <= wr_mapped ? pllcfg_pkg::RESP_OKAY :
              pllcfg_pkg::RESP_SLVERR;
          end
        end
        pllcfg_pkg::WR_RESP: begin
          if (i_bready) begin
            wr_state <= pllcfg_pkg::WR_IDLE;
            o_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= pllcfg_pkg::WR_IDLE;
          o_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------

  // One byte per entry; reserved bits are masked off and read zero, except control bit 5, which is stored
  for (genvar g = 0; g < pllcfg_pkg::CFG_NUM; g++) begin : g_cfg
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cfg[g] <= pllcfg_pkg::RST_TABLE[g];
      end else if (wr_apply && (wr_entry == ENT_W'(g))) begin
        cfg[g] <= wr_data[7:0] &
          pllcfg_pkg::MASK_TABLE[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------

  // Control register fields
  assign o_ref_doubler_enable =
    cfg[0][pllcfg_pkg::DOUBLER_BIT];
  assign o_loop1_pump_gain =
    cfg[0][pllcfg_pkg::PUMP_LSB +: 4];

  // Integer divider joins high nibble and low byte
  assign o_loop1_int_divider = {
    cfg[1][pllcfg_pkg::HIGH_W-1:0],
    cfg[2]};

  // Fractional numerator, top six bits first
  assign o_loop1_frac_numerator = {
    cfg[3][pllcfg_pkg::TOP_W-1:0],
    cfg[4],
    cfg[5]};

  // Fractional denominator, top six bits first
  assign o_loop1_frac_denominator = {
    cfg[6][pllcfg_pkg::TOP_W-1:0],
    cfg[7],
    cfg[8]};

  // Modulator control fields
  assign o_loop1_dither_select =
    cfg[9][pllcfg_pkg::DITHER_LSB +: 2];
  assign o_loop1_modulator_order =
    cfg[9][pllcfg_pkg::ORDER_LSB +: 2];

  // ----------------------------------------------------------------
  // Decoded values
  // ----------------------------------------------------------------

  // Registered decode for the analog loop and divider engine
  pllcfg_field_decode u_decode (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pump_gain(o_loop1_pump_gain),
    .i_int_divider(o_loop1_int_divider),
    .i_dither_select(o_loop1_dither_select),
    .i_modulator_order(o_loop1_modulator_order),
    .o_pump_current(pump_current),
    .o_div_ratio(div_ratio),
    .o_frac_active(frac_active),
    .o_dither_active(dither_active)
  );

  // Decoded values leave on their own ports
  assign o_loop1_pump_current = pump_current;
  assign o_loop1_div_ratio = div_ratio;
  assign o_loop1_frac_active = frac_active;
  assign o_loop1_dither_active = dither_active;

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------

  // A fractional order with a zero denominator cannot divide
  assign den_zero = (o_loop1_frac_denominator == 22'h00_0000);

  // Fault flag held in a flip-flop so the output is registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loop1_config_fault <= 1'b0;
    end else begin
      o_loop1_config_fault <= den_zero && (o_loop1_modulator_order !=
        pllcfg_pkg::ORDER_INTEGER);
    end
  end

  // Read-only status byte built from decoded state
  always_comb begin
    status = 8'h00;
    status[pllcfg_pkg::STAT_FRAC_BIT] = frac_active;
    status[pllcfg_pkg::STAT_DITHER_BIT] = dither_active;
    status[pllcfg_pkg::STAT_FAULT_BIT] = o_loop1_config_fault;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Word index decode of the read address
  assign rd_index = i_araddr[8:2];
  assign rd_in_page = ((i_araddr >> 9) == '0);

  // The status word is built apart from the stored bytes
  assign rd_is_status = rd_in_page &&
    (rd_index == pllcfg_pkg::IDX_STATUS);
  assign rd_mapped = rd_in_page &&
    (rd_index >= pllcfg_pkg::IDX_CONTROL_ONE) &&
    (rd_index <= pllcfg_pkg::IDX_MOD_CONTROL);
  assign rd_entry = ENT_W'(rd_index - pllcfg_pkg::IDX_CONTROL_ONE);

  // Read data select; unmapped words read zero with an error
  always_comb begin
    next_rd_byte = 8'h00;
    next_rd_resp = pllcfg_pkg::RESP_SLVERR;
    if (rd_is_status) begin
      next_rd_byte = status;
      next_rd_resp = pllcfg_pkg::RESP_OKAY;
    end else if (rd_mapped) begin
      next_rd_byte = cfg[rd_entry];
      next_rd_resp = pllcfg_pkg::RESP_OKAY;
    end
  end

  // Address accepted only while no read data is owed
  assign o_arready = (rd_state == pllcfg_pkg::RD_IDLE);

  // Read data channel: data appear the cycle after the address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_state <= pllcfg_pkg::RD_IDLE;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= pllcfg_pkg::RESP_OKAY;
    end else begin
      case (rd_state)
        pllcfg_pkg::RD_IDLE: begin
          if (i_arvalid) begin
            rd_state <= pllcfg_pkg::RD_DATA;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h00_0000, next_rd_byte};
            o_rresp <= next_rd_resp;
          end
        end
        pllcfg_pkg::RD_DATA: begin
          if (i_rready) begin
            rd_state <= pllcfg_pkg::RD_IDLE;
            o_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state <= pllcfg_pkg::RD_IDLE;
          o_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // Protection attributes carry no meaning for this bank
  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot, wr_data[31:8],
    wr_strb[3:1]};

endmodule // pllcfg_regs
`default_nettype wire

// ==== pllcfg_regs_monitor.sv ====
/* Port assertions for the loop one configuration bank.
   Bound to pllcfg_regs; one clock, asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module pllcfg_regs_monitor #(
  parameter int unsigned P_ADDR_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus handshakes
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  // Loop fields
  input wire logic o_ref_doubler_enable,
  input wire logic [3:0] o_loop1_pump_gain,
  input wire logic [11:0] o_loop1_int_divider,
  input wire logic [21:0] o_loop1_frac_denominator,
  input wire logic [1:0] o_loop1_dither_select,
  input wire logic [1:0] o_loop1_modulator_order,
  input wire logic [7:0] o_loop1_pump_current,
  input wire logic [11:0] o_loop1_div_ratio,
  input wire logic o_loop1_frac_active,
  input wire logic o_loop1_dither_active,
  input wire logic o_loop1_config_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Pump code to current in 0.1 mA units, undefined codes give none
  function automatic logic [7:0] pump_dec(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h7) return {2'h0, c, 2'h0};
    return (c == 4'h8) ? 8'h40 : 8'h00;
  endfunction

  // --------------------------------------------------------------
  // Bus steps
  // --------------------------------------------------------------
  sequence wr_take_s;
    i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid;
  endsequence
  sequence rd_take_s;
    i_arvalid && o_arready;
  endsequence

  write_answer_a: assert property (wr_take_s |-> ##2 o_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (rd_take_s |=> o_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read answer dropped or changed");
  upper_zero_a: assert property (
    o_rvalid |-> o_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  reset_value_a: assert property (
    $rose(i_rst_n) |-> o_ref_doubler_enable
    && o_loop1_pump_gain == 4'h8 && o_loop1_int_divider == 12'h066
    && o_loop1_dither_select == 2'h3 && o_loop1_modulator_order == 2'h0)
    else $error("fields wrong after reset");
  pump_map_a: assert property (
    o_loop1_pump_current == pump_dec($past(o_loop1_pump_gain)))
    else $error("pump current decode wrong");
  ratio_map_a: assert property (o_loop1_div_ratio ==
    (($past(o_loop1_int_divider) == 12'h000) ? 12'h001
    : $past(o_loop1_int_divider))) else $error("divide ratio wrong");
  frac_flag_a: assert property (
    o_loop1_frac_active == ($past(o_loop1_modulator_order) != 2'h0))
    else $error("fractional flag wrong");
  dither_flag_a: assert property (
    o_loop1_dither_active == ($past(o_loop1_dither_select) != 2'h3))
    else $error("dither flag wrong");
  fault_flag_a: assert property (o_loop1_config_fault ==
    ($past(o_loop1_modulator_order) != 2'h0
    && $past(o_loop1_frac_denominator) == 22'h00_0000))
    else $error("config fault flag wrong");
endmodule // pllcfg_regs_monitor
`default_nettype wire

// ==== test_pllcfg_regs.sv ====
/* Self-checking bench for the loop one configuration bank.
   Assumes pllcfg_pkg, the bank and its monitor are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_pllcfg_regs;
  // Bench signals
  logic i_clk = 1'b0;
  logic i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [11:0] awaddr, araddr, idiv, rat;
  logic [31:0] wdata, rdata, lfsr_q;
  logic [3:0] wstrb, pg;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp, dth, ord;
  logic [21:0] num, den;
  logic [7:0] pc, mdl [10];
  logic dbl, fa, da, cf;
  logic [34:0] exp_q [$];
  logic [34:0] e_cur;
  int n_mismatch = 0;
  int compares = 0;
  // Reset values and writable bits, control register first
  logic [7:0] rst_v [10] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h0c};
  logic [7:0] msk_v [10] = '{8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'h3f, 8'hff, 8'hff, 8'h0f};
  logic [11:0] dv_t [3] = '{12'h000, 12'h001, 12'hfff};

  // Bank under test
  pllcfg_regs #(.P_ADDR_W(12)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(awaddr), .i_awprot(awprot),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(araddr), .i_arprot(arprot), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(rdata), .o_rresp(rresp),
    .o_ref_doubler_enable(dbl), .o_loop1_pump_gain(pg),
    .o_loop1_int_divider(idiv), .o_loop1_frac_numerator(num),
    .o_loop1_frac_denominator(den), .o_loop1_dither_select(dth),
    .o_loop1_modulator_order(ord), .o_loop1_pump_current(pc),
    .o_loop1_div_ratio(rat), .o_loop1_frac_active(fa),
    .o_loop1_dither_active(da), .o_loop1_config_fault(cf));

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] ad(input int i);
    return {3'h0, 7'(pllcfg_pkg::IDX_CONTROL_ONE + 7'(i)), 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // --------------------------------------------------------------
  // Bus master
  // --------------------------------------------------------------
  // Ready raised after a random stall, held until the answer is taken
  task automatic resp_wait(input logic rd_q);
    logic hs;
    @(posedge i_clk);
    repeat (lfsr_q[1:0]) @(posedge i_clk);
    i_bready <= !rd_q;
    i_rready <= rd_q;
    do begin
      @(negedge i_clk);
      hs = rd_q ? (o_rvalid === 1'b1) : (o_bvalid === 1'b1);
      @(posedge i_clk);
    end while (!hs);
    i_bready <= 1'b0;
    i_rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    lfsr_q = lfsr(lfsr_q);
    exp_q.push_back({1'b0, er, 32'h0000_0000});
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    awaddr <= a;
    awprot <= lfsr_q[2:0];
    wdata <= {lfsr_q[31:8], d};
    wstrb <= s;
    do begin
      @(negedge i_clk);
      aw = aw || o_awready === 1'b1;
      w = w || o_wready === 1'b1;
      @(posedge i_clk);
      if (aw) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
    end while (!(aw && w));
    resp_wait(1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    logic hs;
    lfsr_q = lfsr(lfsr_q);
    exp_q.push_back({1'b1, er, ed});
    i_arvalid <= 1'b1;
    araddr <= a;
    arprot <= lfsr_q[2:0];
    do begin
      @(negedge i_clk);
      hs = o_arready === 1'b1;
      @(posedge i_clk);
    end while (!hs);
    i_arvalid <= 1'b0;
    resp_wait(1'b1);
  endtask

  // Compare each bus answer with the oldest expectation
  always @(negedge i_clk) begin
    if ((o_bvalid && i_bready) === 1'b1 ||
        (o_rvalid && i_rready) === 1'b1) begin
      e_cur = exp_q.pop_front();
      chk("resp", 32'(e_cur[33:32]), 32'(o_rvalid ? rresp : bresp));
      if (e_cur[34]) chk("rdata", e_cur[31:0], rdata); // bytes
    end
  end

  // --------------------------------------------------------------
  // Scenario helpers
  // --------------------------------------------------------------
  task automatic wm(input int i, input logic [7:0] d);
    wr(ad(i), d, 4'h1, 2'h0);
    mdl[i] = d & msk_v[i];
  endtask

  task automatic chk_fields;
    logic [3:0] g;
    logic [11:0] dv;
    logic [7:0] pe;
    g = mdl[0][3:0];
    dv = {mdl[1][3:0], mdl[2]};
    pe = (g == 4'h8) ? 8'h40 :
      ((g != 4'h0 && g < 4'h8) ? {2'h0, g, 2'h0} : 8'h00);
    @(negedge i_clk);
    chk("doubler", 32'(mdl[0][4]), 32'(dbl)); // doubler
    chk("pump", 32'(g), 32'(pg)); // gain
    chk("current", 32'(pe), 32'(pc)); // current
    chk("divider", 32'(dv), 32'(idiv)); // bytes
    chk("ratio", 32'((dv == 12'h000) ? 12'h001 : dv), 32'(rat));
    chk("num", 32'({mdl[3][5:0], mdl[4], mdl[5]}), 32'(num));
    chk("den", 32'({mdl[6][5:0], mdl[7], mdl[8]}), 32'(den));
    chk("dither", 32'(mdl[9][3:2]), 32'(dth)); // dither
    chk("order", 32'(mdl[9][1:0]), 32'(ord)); // order
    @(posedge i_clk); // next request starts after a rising edge
  endtask

  task automatic chk_all;
    logic [21:0] dz;
    for (int i = 0; i < 10; i++) rd(ad(i), 32'(mdl[i]), 2'h0);
    dz = {mdl[6][5:0], mdl[7], mdl[8]};
    rd(ad(10), 32'({dz == 22'h0 && mdl[9][1:0] != 2'h0,
      mdl[9][3:2] != 2'h3, mdl[9][1:0] != 2'h0}), 2'h0);
    chk_fields();
  endtask

  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    mdl = rst_v;
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    lfsr_q = 32'h0000_61a5;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
    do_reset();
    chk_all();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) wm(i, lfsr_q[15:8]);
      chk_all();
    end
    wm(8, 8'h01); // nonzero denominator first
    for (int c = 0; c < 16; c++) begin
      wm(0, 8'(c));
      wm(9, 8'(c));
      chk_fields(); // every code
    end
    foreach (dv_t[k]) begin
      wm(1, {4'hf, dv_t[k][11:8]});
      wm(2, dv_t[k][7:0]);
      chk_fields(); // boundaries
    end
    wr(12'h010, 8'hff, 4'h1, pllcfg_pkg::RESP_SLVERR);
    wr(12'h9e4, 8'hff, 4'h1, pllcfg_pkg::RESP_SLVERR);
    rd(12'h9e4, 32'h0000_0000, pllcfg_pkg::RESP_SLVERR);
    rd(12'h010, 32'h0000_0000, pllcfg_pkg::RESP_SLVERR);
    wr(ad(0), 8'h2a, 4'h0, 2'h0);
    wr(12'h10c, 8'hff, 4'h1, 2'h0);
    chk_all();
    do_reset();
    chk_all();
    final_report();
  end

  // Watchdog
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule // test_pllcfg_regs

bind pllcfg_regs pllcfg_regs_monitor #(.P_ADDR_W(P_ADDR_W)) mon_u (
  .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata,
  .o_rresp, .o_ref_doubler_enable, .o_loop1_pump_gain,
  .o_loop1_int_divider, .o_loop1_frac_denominator, .o_loop1_dither_select,
  .o_loop1_modulator_order, .o_loop1_pump_current, .o_loop1_div_ratio,
  .o_loop1_frac_active, .o_loop1_dither_active, .o_loop1_config_fault);
`default_nettype wire
